//--- core/crcfmt_top.sv
// check-code verification on host writes, error side effects, read frame
// formatting with appended check bytes
// assumes a serial byte engine on pclk delivers received bytes and asks
// for each transmit byte; avg_done and event_flags arrive asynchronously
// Functional notes
// - bad check byte discards the command and sets the error flag
// - reads keep working while the error flag is set
// - serial register writes are refused while the error flag is set; apb writes still land
// - writes to status and main config stay allowed; a main config write with the flag bit set clears it
// - with channel reset enabled, an error forces all channels analog
// - clearing the flag restores channels from pin and direction config
// - with stop enabled, an error halts autonomous and turbo conversions
// - with alert enabled, an error drives the alert pin
// - each transmitted byte is followed by its check byte
// - plain read: result 11..4, then 3..0 and four zeros
// - averaged read: 16-bit average, high byte first
// - appended nibble sits below the 12-bit result, two bytes total
// - average with nibble: three bytes, nibble then four zeros
// - status nibble is one, zero, error flag, alert
// - nibble error bit mirrors config, alert is or of event flags
// - clock held low until averaging completes
// - check byte is crc x^8+x^2+x+1 from zero preset
// - checking and generation only when check enable is set
//
// Added by the designer: the APB slave port and the register offsets.
`default_nettype none
module crcfmt_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire crcfmt_pkg::crcfmt_rx_t  rx,
  input  wire logic                    tx_start,
  input  wire logic                    tx_req,
  output logic                         tx_valid,
  output logic [7:0]                   tx_data,
  output crcfmt_pkg::crcfmt_wr_t       wr,
  input  wire logic [11:0]             conv_result,
  input  wire logic [15:0]             avg_result,
  input  wire logic                    avg_en,
  input  wire logic                    avg_done,
  input  wire logic [1:0]              conv_mode,
  input  wire logic [7:0]              event_flags,
  input  wire logic [3:0]              chan_id,
  output logic                         scl_hold,
  output logic                         alert,
  output logic                         conv_halt,
  output logic [7:0]                   chan_digital,
  output logic [7:0]                   chan_drive
);
  // configuration
  logic [7:0]  gencfg_q;
  logic [7:0]  pin_q;
  logic [7:0]  gpio_q;
  logic        flag_q;
  logic        flag_d;
  logic        force_q;
  logic        force_d;
  logic        halt_q;
  logic        alert_q;
  logic [7:0]  chdig_q;
  logic [7:0]  chdrv_q;

  wire crc_en = gencfg_q[crcfmt_pkg::B_CRC_EN];
  wire channel_reset_on_error = gencfg_q[crcfmt_pkg::B_CHANNEL_RESET_ON_ERROR];
  wire conv_stop = gencfg_q[crcfmt_pkg::B_CONV_STOP];
  wire alert_en = gencfg_q[crcfmt_pkg::B_ALERT_ERR];
  wire [1:0] app_sel = gencfg_q[crcfmt_pkg::B_APP_LO +: 2];

  // synchronised converter levels
  logic        done_s;
  logic [7:0]  ev_s;

  crcfmt_sync2 #(
    .W(9)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({avg_done, event_flags}),
    .q       ({done_s, ev_s})
  );

  // apb slave: one wait state, pready from a flop
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  wire access = psel & penable;
  wire take = access & pready_q;
  wire apb_wr = take & pwrite;
  wire hit_gen = paddr == crcfmt_pkg::OFS_GENCFG;
  wire hit_pin = paddr == crcfmt_pkg::OFS_PINCFG;
  wire hit_gpio = paddr == crcfmt_pkg::OFS_GPIOCFG;
  wire hit_stat = paddr == crcfmt_pkg::OFS_STATUS;
  wire hit_any = hit_gen | hit_pin | hit_gpio | hit_stat;
  wire [7:0] gen_view = {gencfg_q[7], flag_q, gencfg_q[5:0]};
  wire [7:0] stat_view = {4'h0, alert_q, halt_q, force_q, flag_q};
  wire [7:0] rd_mux = hit_gen ? gen_view :
                      hit_pin ? pin_q :
                      hit_gpio ? gpio_q :
                      hit_stat ? stat_view : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~hit_any;
      prdata_q <= (access & ~pready_q & ~pwrite) ? {24'h0, rd_mux} : 32'h0;
    end
  end

  // receive side: data byte, then its check byte when enabled
  crcfmt_pkg::crcfmt_rx_st_t rx_st_q;
  crcfmt_pkg::crcfmt_rx_st_t rx_st_d;
  logic [7:0]  rx_byte_q;
  logic [1:0]  rx_cnt_q;
  logic [7:0]  cmd_addr_q;
  logic [7:0]  cmd_data_q;
  logic [7:0]  rx_crc;
  crcfmt_pkg::crcfmt_wr_t wr_q;

  crcfmt_crc8 u_rx_crc (
    .data (rx_byte_q),
    .crc  (rx_crc)
  );

  wire in_data = rx_st_q == crcfmt_pkg::RX_DATA;
  wire in_check = rx_st_q == crcfmt_pkg::RX_CHECK;
  wire got_data = rx.valid & in_data;
  wire got_check = rx.valid & in_check;
  wire crc_bad = got_check & (rx.data != rx_crc);
  wire err_pulse = crc_bad & crc_en;
  // a byte counts once its check byte matched, or at once without checking
  wire accept = (got_data & ~crc_en) | (got_check & ~crc_bad);
  wire [7:0] acc_byte = in_check ? rx_byte_q : rx.data;
  wire commit = rx.stop & in_data & (rx_cnt_q == 2'h2);
  wire allowed = (cmd_addr_q == crcfmt_pkg::SER_SYS_STATUS) |
                 (cmd_addr_q == crcfmt_pkg::SER_GEN_CFG);
  wire do_write = commit & (~flag_q | allowed);
  wire ser_gen = do_write & (cmd_addr_q == crcfmt_pkg::SER_GEN_CFG);

  always_comb begin
    rx_st_d = rx_st_q;
    case (rx_st_q)
      crcfmt_pkg::RX_IDLE: begin
        if (rx.start) begin
          rx_st_d = crcfmt_pkg::RX_DATA;
        end
      end
      crcfmt_pkg::RX_DATA: begin
        if (rx.stop) begin
          rx_st_d = crcfmt_pkg::RX_IDLE;
        end else if (rx.valid & crc_en) begin
          rx_st_d = crcfmt_pkg::RX_CHECK;
        end
      end
      crcfmt_pkg::RX_CHECK: begin
        if (rx.stop) begin
          rx_st_d = crcfmt_pkg::RX_IDLE;
        end else if (crc_bad) begin
          rx_st_d = crcfmt_pkg::RX_DROP;
        end else if (rx.valid) begin
          rx_st_d = crcfmt_pkg::RX_DATA;
        end
      end
      crcfmt_pkg::RX_DROP: begin
        if (rx.stop) begin
          rx_st_d = crcfmt_pkg::RX_IDLE;
        end
      end
      default: begin
        rx_st_d = crcfmt_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= crcfmt_pkg::RX_IDLE;
      rx_byte_q <= 8'h00;
      rx_cnt_q <= 2'h0;
      cmd_addr_q <= 8'h00;
      cmd_data_q <= 8'h00;
      wr_q <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      if (got_data) begin
        rx_byte_q <= rx.data;
      end
      if (rx.start) begin
        rx_cnt_q <= 2'h0;
      end else if (accept & (rx_cnt_q != 2'h2)) begin
        rx_cnt_q <= rx_cnt_q + 2'h1;
      end
      if (accept & (rx_cnt_q == 2'h0)) begin
        cmd_addr_q <= acc_byte;
      end
      if (accept & (rx_cnt_q == 2'h1)) begin
        cmd_data_q <= acc_byte;
      end
      wr_q.valid <= do_write;
      wr_q.addr <= cmd_addr_q;
      wr_q.data <= cmd_data_q;
    end
  end

  // error flag: a new error wins over a clear in the same cycle
  wire apb_gen = apb_wr & hit_gen;
  wire flag_clr = (apb_gen & pwdata[crcfmt_pkg::B_FLAG]) |
                  (ser_gen & cmd_data_q[crcfmt_pkg::B_FLAG]);
  wire auto_mode = (conv_mode == crcfmt_pkg::MODE_AUTO) |
                   (conv_mode == crcfmt_pkg::MODE_TURBO);

  assign flag_d = err_pulse | (flag_q & ~flag_clr);
  assign force_d = (err_pulse & channel_reset_on_error) | (force_q & flag_d);
  wire halt_d = (err_pulse & conv_stop & auto_mode) | (halt_q & flag_d);
  wire alert_d = (err_pulse & alert_en) | (alert_q & flag_d);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gencfg_q <= crcfmt_pkg::GENCFG_RST;
      pin_q <= crcfmt_pkg::PIN_RST;
      gpio_q <= crcfmt_pkg::PIN_RST;
      flag_q <= 1'b0;
      force_q <= 1'b0;
      halt_q <= 1'b0;
      alert_q <= 1'b0;
      chdig_q <= 8'h00;
      chdrv_q <= 8'h00;
    end else begin
      if (apb_gen) begin
        gencfg_q <= pwdata[7:0];
      end else if (ser_gen) begin
        gencfg_q <= cmd_data_q;
      end
      if (apb_wr & hit_pin) begin
        pin_q <= pwdata[7:0];
      end
      if (apb_wr & hit_gpio) begin
        gpio_q <= pwdata[7:0];
      end
      flag_q <= flag_d;
      force_q <= force_d;
      halt_q <= halt_d;
      alert_q <= alert_d;
      // forced channels release no drive at all
      chdig_q <= force_d ? 8'h00 : pin_q;
      chdrv_q <= force_d ? 8'h00 : (pin_q & gpio_q);
    end
  end

  // read-out formatting
  wire app_on = (app_sel == crcfmt_pkg::APP_CHID) |
                (app_sel == crcfmt_pkg::APP_STATUS);
  wire [3:0] stat_nib = {1'b1, 1'b0, flag_q, |ev_s};
  wire [3:0] nib = (app_sel == crcfmt_pkg::APP_STATUS) ? stat_nib : chan_id;
  wire [7:0] byte0 = avg_en ? avg_result[15:8] : conv_result[11:4];
  wire [7:0] byte1 = avg_en ? avg_result[7:0] :
                     {conv_result[3:0], app_on ? nib : 4'h0};
  wire [7:0] byte2 = (avg_en & app_on) ? {nib, 4'h0} : 8'h00;
  logic [1:0]  tx_idx_q;
  logic        crc_turn_q;
  logic        pend_q;
  logic        hold_q;
  logic        txv_q;
  logic [7:0]  txd_q;
  logic [7:0]  last_q;
  logic [7:0]  tx_crc;

  crcfmt_crc8 u_tx_crc (
    .data (last_q),
    .crc  (tx_crc)
  );
  wire [7:0] cur_byte = (tx_idx_q == 2'h0) ? byte0 :
                        (tx_idx_q == 2'h1) ? byte1 :
                        (tx_idx_q == 2'h2) ? byte2 : 8'h00;

  // a byte stays pending while the average is unfinished
  wire waiting = pend_q | tx_req;
  wire stall = avg_en & ~done_s;
  wire deliver = waiting & ~stall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_idx_q <= 2'h0;
      crc_turn_q <= 1'b0;
      pend_q <= 1'b0;
      hold_q <= 1'b0;
      txv_q <= 1'b0;
      txd_q <= 8'h00;
      last_q <= 8'h00;
    end else begin
      pend_q <= waiting & stall;
      hold_q <= waiting & stall;
      txv_q <= deliver & ~tx_start;
      if (tx_start) begin
        tx_idx_q <= 2'h0;
        crc_turn_q <= 1'b0;
        pend_q <= 1'b0;
        hold_q <= 1'b0;
      end else if (deliver) begin
        if (crc_turn_q) begin
          txd_q <= tx_crc;
          crc_turn_q <= 1'b0;
        end else begin
          txd_q <= cur_byte;
          last_q <= cur_byte;
          crc_turn_q <= crc_en;
        end
        if ((crc_turn_q | ~crc_en) & (tx_idx_q != 2'h3)) begin
          tx_idx_q <= tx_idx_q + 2'h1;
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_valid = txv_q;
  assign tx_data = txd_q;
  assign wr = wr_q;
  assign scl_hold = hold_q;
  assign alert = alert_q;
  assign conv_halt = halt_q;
  assign chan_digital = chdig_q;
  assign chan_drive = chdrv_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  crc_err_set_a: assert property (err_pulse |=> flag_q ##1 flag_q [*1])
    else $error("check error did not set the flag");
  err_drop_a: assert property (err_pulse |=> !wr_q.valid [*2])
    else $error("command written after a check error");
  write_block_a: assert property (
    (wr_q.valid && $past(flag_q)) |->
      (wr_q.addr == crcfmt_pkg::SER_SYS_STATUS ||
       wr_q.addr == crcfmt_pkg::SER_GEN_CFG))
    else $error("blocked write reached the register file");
  ch_force_a: assert property ((err_pulse && channel_reset_on_error) |=> chdrv_q == 8'h00)
    else $error("channel still driven after error");
  restore_a: assert property ($fell(flag_q) |-> chdrv_q == $past(pin_q & gpio_q))
    else $error("channel config not restored");
  halt_a: assert property ((err_pulse && conv_stop && auto_mode) |=> halt_q)
    else $error("conversions not halted");
  alert_a: assert property ((err_pulse && alert_en) |=> alert && flag_q)
    else $error("alert not raised on check error");
  tx_crc_a: assert property (
    (deliver && !tx_start && crc_turn_q) |=> tx_valid && tx_data == $past(tx_crc))
    else $error("check byte missing after data byte");
  hold_a: assert property ((waiting && stall && !tx_start) |=> scl_hold && !tx_valid)
    else $error("data sent before averaging completed");
  apb_rdy_a: assert property ((access && !pready_q) |=> pready_q)
    else $error("apb answer late");

  err_seen_c: cover property (err_pulse ##[1:20] flag_clr);
  write_done_c: cover property (wr_q.valid);
  hold_seen_c: cover property (hold_q ##[1:50] tx_valid);
  three_byte_c: cover property (tx_valid && tx_idx_q == 2'h3 && avg_en && app_on);
endmodule : crcfmt_top
`default_nettype wire

//--- core/crcfmt_pkg.sv
// shared constants and carrier types for the check-code and read-out block
// assumes the apb slave and the serial byte engine share pclk
`default_nettype none
package crcfmt_pkg;
  // apb byte offsets
  localparam logic [7:0] OFS_GENCFG = 8'h00;
  localparam logic [7:0] OFS_PINCFG = 8'h04;
  localparam logic [7:0] OFS_GPIOCFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // control register fields
  localparam int B_CRC_EN = 0;
  localparam int B_CHANNEL_RESET_ON_ERROR = 1;
  localparam int B_CONV_STOP = 2;
  localparam int B_ALERT_ERR = 3;
  localparam int B_APP_LO = 4;
  localparam int B_FLAG = 6;
  localparam logic [7:0] GENCFG_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'h00;
  // serial-side register addresses that stay writable after an error
  localparam logic [7:0] SER_SYS_STATUS = 8'h00;
  localparam logic [7:0] SER_GEN_CFG = 8'h01;
  // nibble_append_select codes
  localparam logic [1:0] APP_NONE = 2'h0;
  localparam logic [1:0] APP_CHID = 2'h1;
  localparam logic [1:0] APP_STATUS = 2'h2;
  // conversion modes
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_TURBO = 2'h2;
  // check code: x^8+x^2+x+1, zero preset
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef struct packed {
    logic       valid;
    logic       start;
    logic       stop;
    logic [7:0] data;
  } crcfmt_rx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } crcfmt_wr_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_DATA  = 2'b01,
    RX_CHECK = 2'b10,
    RX_DROP  = 2'b11
  } crcfmt_rx_st_t;
endpackage : crcfmt_pkg
`default_nettype wire

//--- core/crcfmt_crc8.sv
// check code of a single byte, msb first
// purely combinational, no clock
`default_nettype none
module crcfmt_crc8 (
  input  wire logic [7:0] data,
  output logic [7:0]      crc
);
  function automatic logic [7:0] crc_byte(input logic [7:0] d);
    logic [7:0] c;
    c = crcfmt_pkg::CRC_INIT;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ crcfmt_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_byte

  assign crc = crc_byte(data);
endmodule : crcfmt_crc8
`default_nettype wire

//--- core/crcfmt_sync2.sv
// two-flop synchroniser for levels from outside the pclk domain
// assumes each bit is an independent slow level
`default_nettype none
module crcfmt_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : crcfmt_sync2
`default_nettype wire

//--- verif/crcfmt_host_model.sv
// host-side model of the serial link: feeds received bytes, asks for transmit bytes
// assumes the block's byte engine runs on pclk and shows one byte per rx pulse
`default_nettype none
module crcfmt_host_model (
  input  wire logic                    pclk,
  input  wire logic                    tx_valid,
  output var  crcfmt_pkg::crcfmt_rx_t  rx,
  output var  logic                    tx_start,
  output var  logic                    tx_req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx = '0;
    tx_start = 1'b0;
    tx_req = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = d; // a zero preset folds into the first shift
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8

  task automatic put(input logic v, input logic s, input logic p, input logic [7:0] d);
    @(posedge pclk);
    rx <= '{valid: v, start: s, stop: p, data: d};
  endtask : put

  // start and stop idle bytes carry the inverse of the data byte so stale data cannot pass
  task automatic send(input logic [7:0] a, input logic [7:0] d, input logic crc_on,
                      input logic bad);
    put(1'b0, 1'b1, 1'b0, ~d);
    put(1'b1, 1'b0, 1'b0, a);
    if (crc_on) put(1'b1, 1'b0, 1'b0, crc8(a)); // register byte is data: checked
    put(1'b1, 1'b0, 1'b0, d);
    if (crc_on) put(1'b1, 1'b0, 1'b0, crc8(d) ^ {7'h00, bad});
    put(1'b0, 1'b0, 1'b1, ~d);
    put(1'b0, 1'b0, 1'b0, d);
  endtask : send

  task automatic fetch(input int n);
    @(posedge pclk);
    tx_start <= 1'b1;
    repeat (n) begin
      @(posedge pclk);
      tx_start <= 1'b0;
      tx_req <= 1'b1;
      @(posedge pclk);
      tx_req <= 1'b0;
      for (int w = 0; w < 60 && tx_valid !== 1'b1; w++) @(posedge pclk);
    end
  endtask : fetch
endmodule : crcfmt_host_model
`default_nettype wire

//--- verif/crcfmt_top_tb.sv
// self-checking bench: apb master, serial host model, queued expectations
// assumes the host model file is compiled before this one
`default_nettype none
module crcfmt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                   tx_start, tx_req, tx_valid, avg_en, avg_done, scl_hold, alert, conv_halt;
  logic [7:0]             paddr, tx_data, chan_digital, chan_drive, event_flags, nib;
  logic [31:0]            pwdata, prdata, rd;
  logic [11:0]            conv_result;
  logic [15:0]            avg_result, v;
  logic [1:0]             conv_mode;
  logic [3:0]             chan_id;
  crcfmt_pkg::crcfmt_rx_t rx;
  crcfmt_pkg::crcfmt_wr_t wr;
  int                     err_total, comparisons, cycles, seed;
  logic [7:0]             tx_q[$];
  logic [15:0]            wr_q[$];

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  crcfmt_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx(rx), .tx_start(tx_start), .tx_req(tx_req), .tx_valid(tx_valid),
    .tx_data(tx_data), .wr(wr), .conv_result(conv_result), .avg_result(avg_result),
    .avg_en(avg_en), .avg_done(avg_done), .conv_mode(conv_mode), .event_flags(event_flags),
    .chan_id(chan_id), .scl_hold(scl_hold), .alert(alert), .conv_halt(conv_halt),
    .chan_digital(chan_digital), .chan_drive(chan_drive));
  crcfmt_host_model host_u (.pclk(pclk), .tx_valid(tx_valid), .rx(rx), .tx_start(tx_start),
    .tx_req(tx_req));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic exp_tx(input logic [7:0] b, input logic crc_on);
    tx_q.push_back(b);
    if (crc_on) tx_q.push_back(host_u.crc8(b));
  endtask : exp_tx

  // flop outputs read at the edge still hold what the previous edge loaded
  always @(posedge pclk) begin
    cycles++;
    if (tx_valid === 1'b1) begin
      check({24'h0, tx_data}, tx_q.size() ? {24'h0, tx_q.pop_front()} : 32'hFFFF_FFFF,
            "tx_data");
    end
    if (wr.valid === 1'b1) begin
      check({wr.addr, wr.data}, wr_q.size() ? wr_q.pop_front() : 32'hFFFF_FFFF,
            "wr");
    end
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    seed = 32'h77B4FF65;
    {presetn, psel, penable, pwrite, paddr, pwdata, avg_en, avg_done} = '0;
    conv_result = '0;
    avg_result = '0;
    conv_mode = crcfmt_pkg::MODE_AUTO;
    event_flags = 8'($random(seed));
    chan_id = 4'($random(seed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, crcfmt_pkg::OFS_GENCFG, 32'h0);
    check(rd, 32'h0, "gencfg reset");
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1, "pslverr");
    apb(1'b1, crcfmt_pkg::OFS_PINCFG, 32'hFF);
    apb(1'b1, crcfmt_pkg::OFS_GPIOCFG, 32'h0F);
    apb(1'b1, crcfmt_pkg::OFS_GENCFG, 32'h2F);
    v = 16'($random(seed));
    wr_q.push_back({8'h02, v[7:0]});
    host_u.send(8'h02, v[7:0], 1'b1, 1'b0);
    host_u.send(8'h03, v[7:0], 1'b1, 1'b1);
    repeat (4) @(posedge pclk);
    check({31'h0, alert}, 32'h1, "alert");
    check({31'h0, conv_halt}, 32'h1, "halt");
    check({chan_digital, chan_drive}, 32'h0, "forced chans");
    apb(1'b0, crcfmt_pkg::OFS_GENCFG, 32'h0);
    check(rd, 32'h6F, "gencfg flag");
    apb(1'b0, crcfmt_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0F, "status");
    host_u.send(8'h05, v[15:8], 1'b1, 1'b0);
    wr_q.push_back({crcfmt_pkg::SER_SYS_STATUS, v[15:8]});
    host_u.send(crcfmt_pkg::SER_SYS_STATUS, v[15:8], 1'b1, 1'b0);
    v = 16'($random(seed));
    conv_result <= v[11:0];
    exp_tx(v[11:4], 1'b1);
    exp_tx({v[3:0], 3'b101, |event_flags}, 1'b1);
    host_u.fetch(4);
    wr_q.push_back({crcfmt_pkg::SER_GEN_CFG, 8'h4F});
    host_u.send(crcfmt_pkg::SER_GEN_CFG, 8'h4F, 1'b1, 1'b0);
    repeat (4) @(posedge pclk);
    check({30'h0, alert, conv_halt}, 32'h0, "released");
    check({chan_digital, chan_drive}, 32'hFF0F, "restored chans");
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, crcfmt_pkg::OFS_GENCFG, {26'h0, k[1:0], 4'h0});
      v = 16'($random(seed));
      conv_result <= v[11:0];
      nib = (k == 0) ? 8'h0 : (k == 1) ? {4'h0, chan_id} : {4'h0, 3'b100, |event_flags};
      exp_tx(v[11:4], 1'b0);
      exp_tx({v[3:0], nib[3:0]}, 1'b0);
      host_u.fetch(2);
    end
    wr_q.push_back({8'h02, v[7:0]});
    host_u.send(8'h02, v[7:0], 1'b0, 1'b0);
    apb(1'b1, crcfmt_pkg::OFS_GENCFG, 32'h11);
    v = 16'($random(seed));
    avg_result <= v;
    avg_en <= 1'b1;
    exp_tx(v[15:8], 1'b1);
    exp_tx(v[7:0], 1'b1);
    exp_tx({chan_id, 4'h0}, 1'b1);
    fork
      host_u.fetch(6);
      begin
        repeat (10) @(posedge pclk);
        check({31'h0, scl_hold}, 32'h1, "scl_hold");
        avg_done <= 1'b1;
      end
    join
    apb(1'b1, crcfmt_pkg::OFS_GENCFG, 32'h01);
    v = 16'($random(seed));
    avg_result <= v;
    exp_tx(v[15:8], 1'b1);
    exp_tx(v[7:0], 1'b1);
    host_u.fetch(4);
    repeat (5) @(posedge pclk);
    check(32'(tx_q.size() + wr_q.size()), 32'h0, "pending");
    give_verdict();
  end
endmodule : crcfmt_top_tb
`default_nettype wire
